// ==== hw/fgf_divider.sv ====
// Divider producing the one-cycle filter sampling enable
`timescale 1ns/1ps
`default_nettype none
module fgf_divider
  import fgf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [FGF_DIV_W-1:0] div_period,
  fgf_tick_if.src tk
);
  logic [FGF_DIV_W-1:0] div_cnt;

  // Count clk cycles; tick once per div_period+1 cycles
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      div_cnt <= FGF_DIV_RST;
    end else if (div_cnt >= div_period) begin
      div_cnt <= FGF_DIV_RST;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Rising edge of the filter clock
  assign tk.tick = run && !rst && (div_cnt >= div_period);
endmodule : fgf_divider
`default_nettype wire

// ==== hw/fgf_filter.sv ====
// Fast input glitch filter: qualifies a raw input before the pulse counter
// Function
// - Sample the raw input once on every filter clock rising edge.
// - Count filter edges; clear the counter on reaching the configured count.
// - On count completion with stable level, forward that level to the counter.
// - Level change before completion clears counter and restarts from new level.
// - Output lags input at least sample count times filter period; both configurable.
`timescale 1ns/1ps
`default_nettype none
module fgf_filter
  import fgf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_in,
  input wire logic filt_en,
  input wire logic [FGF_DIV_W-1:0] div_period,
  input wire logic [FGF_CNT_W-1:0] sample_num,
  output logic fast_pulse_counter_in,
  output logic sample_tick
);
  fgf_tick_if tk ();
  fgf_mode_e mode;
  logic last_level;
  logic [FGF_CNT_W-1:0] sample_cnt;
  logic target_hit;

  // Filter clock generator; concerns software choice of div_period
  fgf_divider u_div (
    .clk(clk),
    .rst(rst),
    .run(filt_en),
    .div_period(div_period),
    .tk(tk)
  );

  assign sample_tick = tk.tick;
  assign mode = filt_en ? FGF_QUALIFY : FGF_BYPASS;
  // Zero samples treated as one so the filter still advances
  assign target_hit = (sample_cnt + 8'h01 >= sample_num);

  // Sample the input on each filter edge
  always_ff @(posedge clk) begin
    if (rst) begin
      last_level <= FGF_LEVEL_RST;
    end else if (mode == FGF_BYPASS) begin
      last_level <= raw_in;
    end else if (tk.tick) begin
      last_level <= raw_in;
    end
  end

  // Sample counter with restart on level change
  always_ff @(posedge clk) begin
    if (rst || mode == FGF_BYPASS) begin
      sample_cnt <= FGF_CNT_RST;
    end else if (tk.tick) begin
      if (raw_in != last_level) begin
        sample_cnt <= FGF_CNT_RST;
      end else if (target_hit) begin
        sample_cnt <= FGF_CNT_RST;
      end else begin
        sample_cnt <= sample_cnt + 8'h01;
      end
    end
  end

  // Filtered level towards the counter accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_pulse_counter_in <= FGF_LEVEL_RST;
    end else begin
      case (mode)
        FGF_BYPASS: fast_pulse_counter_in <= raw_in;
        FGF_QUALIFY: begin
          if (tk.tick && raw_in == last_level && target_hit) begin
            fast_pulse_counter_in <= last_level;
          end
        end
        default: fast_pulse_counter_in <= FGF_LEVEL_RST;
      endcase
    end
  end

  // Checking aids below feed only the assertions of this module
  // Clocks since the last filter edge, kept apart from the divider
  logic [FGF_DIV_W-1:0] gap_cnt;
  // Clocks since the last level change met on a filter edge
  logic [FGF_DIV_W+FGF_CNT_W-1:0] since_chg;
  // Shortest legal lag in clocks for the present settings
  logic [FGF_DIV_W+FGF_CNT_W-1:0] lag_min;
  // Sample count with zero read as one, as the qualifier does
  logic [FGF_CNT_W-1:0] samples_eff;

  // Phase counter restarted by every filter edge and by bypass
  always_ff @(posedge clk) begin
    if (rst || mode == FGF_BYPASS || tk.tick) begin
      gap_cnt <= FGF_DIV_RST;
    end else begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  // Age of the newest level, saturating so it never wraps to zero
  always_ff @(posedge clk) begin
    if (rst || mode == FGF_BYPASS) begin
      since_chg <= {FGF_CNT_RST, FGF_DIV_RST};
    end else if (tk.tick && raw_in != last_level) begin
      since_chg <= {FGF_CNT_RST, FGF_DIV_RST};
    end else if (since_chg != {8'hff, 16'hffff}) begin
      since_chg <= since_chg + {8'h00, 16'h0001};
    end
  end

  // Minimum lag: sample count times filter period, both in clocks
  assign samples_eff = (sample_num == FGF_CNT_RST) ? 8'h01 : sample_num;
  assign lag_min = ({8'h00, div_period} + {8'h00, 16'h0001}) * {16'h0000, samples_eff};

  // Stable sample seen on an edge
  sequence stable_edge_s;
    tk.tick && filt_en && raw_in == last_level && target_hit;
  endsequence

  // Level change seen on an edge
  sequence change_edge_s;
    tk.tick && filt_en && raw_in != last_level;
  endsequence

  // Clock between filter edges while qualifying
  sequence idle_edge_s;
    filt_en && !tk.tick;
  endsequence

  // Qualified level that differs from what the accumulator holds
  sequence forward_new_s;
    stable_edge_s ##0 last_level != fast_pulse_counter_in;
  endsequence

  // Stable level reaches the accumulator one clock later
  forward_stable_a: assert property (@(posedge clk) disable iff (rst)
    stable_edge_s |=> fast_pulse_counter_in == $past(raw_in))
    else $error("stable level not forwarded");

  // A change on an edge restarts the count
  restart_change_a: assert property (@(posedge clk) disable iff (rst)
    change_edge_s |=> sample_cnt == 8'h00)
    else $error("counter not cleared on change");

  // Count returns to zero at the target
  count_clear_a: assert property (@(posedge clk) disable iff (rst)
    stable_edge_s |=> sample_cnt == 8'h00)
    else $error("counter not cleared at target");

  // Count steps by one on a stable edge short of target
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    tk.tick && filt_en && raw_in == last_level && !target_hit
      |=> sample_cnt == $past(sample_cnt) + 8'h01)
    else $error("counter did not advance");

  // Every filter edge stores the input level
  sample_take_a: assert property (@(posedge clk) disable iff (rst)
    tk.tick && filt_en |=> last_level == $past(raw_in))
    else $error("input not sampled on edge");

  // Output holds between filter edges
  hold_out_a: assert property (@(posedge clk) disable iff (rst)
    filt_en && $past(filt_en) && !$past(tk.tick)
      |-> $stable(fast_pulse_counter_in))
    else $error("output moved between edges");

  // Bypass copies the input each clock
  bypass_pass_a: assert property (@(posedge clk) disable iff (rst)
    !filt_en |=> fast_pulse_counter_in == $past(raw_in))
    else $error("bypass did not pass input");

  // Output moves only on a qualifying edge
  no_early_a: assert property (@(posedge clk) disable iff (rst)
    filt_en && $past(filt_en) && fast_pulse_counter_in != $past(fast_pulse_counter_in)
      |-> $past(tk.tick) && $past(target_hit))
    else $error("output changed before qualification");

  // A filter edge never comes before its period is spent
  tick_due_a: assert property (@(posedge clk) disable iff (rst)
    tk.tick |-> gap_cnt >= div_period)
    else $error("filter edge came early");

  // A filter edge is never skipped once its period is spent
  tick_wait_a: assert property (@(posedge clk) disable iff (rst)
    idle_edge_s |-> gap_cnt < div_period)
    else $error("filter edge missed");

  // Count stays put between filter edges
  idle_count_a: assert property (@(posedge clk) disable iff (rst)
    idle_edge_s |=> sample_cnt == $past(sample_cnt))
    else $error("counter moved between edges");

  // Stored level stays put between filter edges
  idle_level_a: assert property (@(posedge clk) disable iff (rst)
    idle_edge_s |=> last_level == $past(last_level))
    else $error("input sampled between edges");

  // An unqualified change leaves the accumulator input alone
  change_hold_a: assert property (@(posedge clk) disable iff (rst)
    change_edge_s |=> $stable(fast_pulse_counter_in))
    else $error("output followed an unqualified change");

  // A new level is forwarded no sooner than samples times period
  lag_floor_a: assert property (@(posedge clk) disable iff (rst)
    forward_new_s |-> since_chg >= lag_min - {8'h00, 16'h0001})
    else $error("level forwarded too soon");

  // No filter edges while bypassed
  bypass_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !filt_en |-> !tk.tick)
    else $error("filter edge during bypass");

  // Count held at zero while bypassed
  bypass_clear_a: assert property (@(posedge clk) disable iff (rst)
    !filt_en |=> sample_cnt == 8'h00)
    else $error("counter active in bypass");
endmodule : fgf_filter
`default_nettype wire

// ==== hw/fgf_pkg.sv ====
// Package for the fast input glitch filter: widths, clock rate, reset values, qualifier states
package fgf_pkg;
  // Filter clock divider width and sample count width
  localparam int FGF_DIV_W = 16;
  localparam int FGF_CNT_W = 8;
  // Clock rate of the system clock in Hz
  localparam int FGF_CLK_HZ = 125_000_000;
  // Reset values of configuration-derived state
  localparam logic FGF_LEVEL_RST = 1'b0;
  localparam logic [FGF_DIV_W-1:0] FGF_DIV_RST = 16'h0000;
  localparam logic [FGF_CNT_W-1:0] FGF_CNT_RST = 8'h00;
  // Qualifier states
  typedef enum logic [1:0] {
    FGF_BYPASS,
    FGF_QUALIFY
  } fgf_mode_e;
endpackage : fgf_pkg

// ==== hw/fgf_tick_if.sv ====
// Interface carrying the filter sampling tick from divider to qualifier
`timescale 1ns/1ps
`default_nettype none
interface fgf_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : fgf_tick_if
`default_nettype wire

// ==== test/fgf_acc_model.sv ====
// Accumulator model counting rises of the filtered level
`timescale 1ns/1ps
`default_nettype none
module fgf_acc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic lvl,
  output logic [7:0] edges
);
  logic prev;
  // Count each rise of the filtered level
  always_ff @(posedge clk) begin
    prev <= rst ? 1'b0 : lvl;
    edges <= rst ? 8'h00 : edges + 8'(lvl & ~prev);
  end
endmodule : fgf_acc_model
`default_nettype wire

// ==== test/fgf_filter_tb.sv ====
// Testbench for the fast input glitch filter
`timescale 1ns/1ps
`default_nettype none
module fgf_filter_tb;
  import fgf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic raw_in = 1'b0;
  logic filt_en = 1'b0;
  logic [FGF_DIV_W-1:0] div_period = 16'h0000;
  logic [FGF_CNT_W-1:0] sample_num = 8'h02;
  logic fpc, tick;
  logic [7:0] edges;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      conclude();
    end
  end
  fgf_filter uut (.clk(clk), .rst(rst), .raw_in(raw_in), .filt_en(filt_en),
    .div_period(div_period), .sample_num(sample_num),
    .fast_pulse_counter_in(fpc), .sample_tick(tick));
  fgf_acc_model acc (.clk(clk), .rst(rst), .lvl(fpc), .edges(edges));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task conclude();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt
  task t_bypass();
    raw_in = 1'b1;
    wt(1);
    chk(8'(fpc), 8'h01);
    raw_in = 1'b0;
    wt(1);
    chk(8'(fpc), 8'h00);
    $display("bypass done");
  endtask : t_bypass
  task t_qualify();
    filt_en = 1'b1;
    wt(2);
    raw_in = 1'b1;
    wt(2);
    chk(8'(fpc), 8'h00);
    wt(1);
    chk(8'(fpc), 8'h01);
    raw_in = 1'b0;
    wt(1);
    chk(8'(fpc), 8'h01);
    raw_in = 1'b1;
    wt(1);
    chk(8'(fpc), 8'h01);
    wt(5);
    chk(8'(fpc), 8'h01);
    $display("qualify done");
  endtask : t_qualify
  task t_single();
    div_period = 16'h0000;
    sample_num = 8'h00;
    raw_in = 1'b1;
    wt(1);
    chk(8'(fpc), 8'h00);
    wt(1);
    chk(8'(fpc), 8'h01);
    $display("single sample done");
  endtask : t_single
  task t_slow();
    div_period = 16'h0003;
    wt(8);
    n = 0;
    repeat (16) begin
      wt(1);
      n += tick;
    end
    chk(8'(n), 8'h04);
    raw_in = 1'b0;
    wt(8);
    chk(8'(fpc), 8'h01);
    for (n = 0; n < 16 && fpc !== 1'b0; n++) wt(1);
    chk(8'(fpc), 8'h00);
    $display("slow clock done");
  endtask : t_slow
  // Main sequence
  initial begin
    wt(20);
    rst = 1'b0;
    t_bypass();
    t_qualify();
    t_slow();
    t_single();
    wt(1);
    chk(edges, 8'h03);
    conclude();
  end
endmodule : fgf_filter_tb
`default_nettype wire
